// [verilog/asu_pkg.sv]
package asu_pkg;
  // -----------------------------------------------------------------
  // register map (byte addresses on the plain register port)
  // -----------------------------------------------------------------
  localparam logic [15:0] ADDR_RATE   = 16'h102b;  // sample clock divider
  localparam logic [15:0] ADDR_CTRL1  = 16'h102c;  // serial_control_first
  localparam logic [15:0] ADDR_CTRL2  = 16'h102d;  // serial_control_second
  localparam logic [15:0] ADDR_STAT   = 16'h102e;  // serial_status_flags
  localparam logic [15:0] ADDR_DATA   = 16'h102f;  // serial_data_buffer

  // -----------------------------------------------------------------
  // field positions
  // -----------------------------------------------------------------
  localparam int C1_RX9    = 7;  // rx_ninth_bit, read only
  localparam int C1_TX9    = 6;  // tx_ninth_bit
  localparam int C1_WORD9  = 4;  // nine data bits when set
  localparam int C1_WAKE   = 3;  // wake method: 0 idle line, 1 address mark
  localparam int C2_TXON   = 3;  // tx_on
  localparam int C2_RXON   = 2;  // receiver enable
  localparam int C2_SLEEP  = 1;  // rx_sleep
  localparam int C2_BREAK  = 0;  // send break
  localparam int ST_TXE    = 7;  // transmit buffer empty
  localparam int ST_TXC    = 6;  // transmitter idle
  localparam int ST_RXF    = 5;  // rx_full_flag
  localparam int ST_IDLE   = 4;  // idle line
  localparam int ST_OVR    = 3;  // overrun
  localparam int ST_NOISE  = 2;  // noise_flag
  localparam int ST_FRAME  = 1;  // frame_error_flag

  // -----------------------------------------------------------------
  // reset values and timing
  // -----------------------------------------------------------------
  localparam logic [7:0] RATE_RESET = 8'h00;  // sample tick every clock
  localparam logic [7:0] C2_IE_MASK = 8'hf0;  // upper control bits, stored only
  localparam logic [3:0] RT_LAST    = 4'hf;   // sixteen sample ticks per bit
  localparam logic [3:0] SAMP_A     = 4'h7;   // three mid-bit samples
  localparam logic [3:0] SAMP_B     = 4'h8;
  localparam logic [3:0] SAMP_C     = 4'h9;
  localparam logic [3:0] BITS_8     = 4'ha;   // start + 8 data + stop
  localparam logic [3:0] BITS_9     = 4'hb;   // start + 9 data + stop

  typedef enum logic {ASU_RX_IDLE, ASU_RX_BITS} asu_rx_e;
endpackage : asu_pkg

// [verilog/asu_serial.sv]
// The address-and-strobe port is this design's own decision.
`timescale 1ns/1ps
module asu_serial
  import asu_pkg::*;
(
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        nrst,
  // register port
  input  wire logic [15:0] reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  // serial line
  input  wire logic        rxd,
  output logic             txd
);
  import asu_pkg::*;

  // -----------------------------------------------------------------
  // helpers
  // -----------------------------------------------------------------
  // majority of three samples
  function automatic logic vote(input logic [2:0] s);
    vote = (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
  endfunction : vote

  // frame length in bits for the chosen word size
  function automatic logic [3:0] frame_bits(input logic nine);
    frame_bits = nine ? BITS_9 : BITS_8;
  endfunction : frame_bits

  // -----------------------------------------------------------------
  // register state
  // -----------------------------------------------------------------
  logic [7:0]  rate_reg;              // sample tick divider
  logic [7:0]  rate_cnt_reg;          // divider count
  logic        word9_reg;             // nine bit frames
  logic        wake_addr_reg;         // address mark wake
  logic        tx9_reg;               // ninth bit to send
  logic        rx9_reg;               // ninth bit received
  logic [3:0]  c2_hi_reg;             // stored enable bits, no function here
  logic        tx_on_reg;             // transmitter enable
  logic        rx_on_reg;             // receiver enable
  logic        sleep_reg;             // receiver asleep
  logic        brk_reg;               // send break level
  logic [7:0]  tx_buf_reg;            // transmit buffer
  logic [7:0]  rx_buf_reg;            // receive buffer
  logic        txe_reg, txc_reg;      // transmit flags
  logic        rxf_reg, idle_reg;     // receive flags
  logic        ovr_reg, noise_reg;    // error flags
  logic        fe_reg;
  logic [7:0]  arm_reg;               // flags seen by the last status read
  logic [7:0]  status;                // assembled status byte

  // decoded strobes
  logic wr_data, rd_data, rd_stat;
  assign wr_data = reg_wr && (reg_addr == ADDR_DATA);
  assign rd_data = reg_rd && (reg_addr == ADDR_DATA);
  assign rd_stat = reg_rd && (reg_addr == ADDR_STAT);

  // -----------------------------------------------------------------
  // sample clock
  // -----------------------------------------------------------------
  logic rt_tick;                      // one sample tick, sixteen per bit
  assign rt_tick = (rate_cnt_reg == rate_reg);

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      rate_cnt_reg <= 8'h00;
    end else if (rt_tick) begin
      rate_cnt_reg <= 8'h00;
    end else begin
      rate_cnt_reg <= rate_cnt_reg + 8'h01;
    end
  end

  // -----------------------------------------------------------------
  // transmitter
  // -----------------------------------------------------------------
  logic [3:0]  tx_rt_reg;             // sample count within a bit
  logic [10:0] tx_sh_reg;             // shifter, bit 0 is on the line
  logic [3:0]  tx_left_reg;           // bits still to send
  logic        pre_pend_reg;          // preamble queued
  logic        brk_pend_reg;          // one break queued by a write
  logic        tx_on_q_reg;           // previous enable, for rise detect
  logic        bit_tick, tx_load, ld_pre, ld_brk, ld_data;
  logic        tx_busy;

  assign bit_tick = rt_tick && (tx_rt_reg == RT_LAST);
  assign tx_load  = bit_tick && (tx_left_reg <= 4'h1);
  assign ld_pre   = tx_load && pre_pend_reg;
  assign ld_brk   = tx_load && !pre_pend_reg && (brk_reg || brk_pend_reg);
  assign ld_data  = tx_load && !pre_pend_reg && !(brk_reg || brk_pend_reg)
                    && !txe_reg && tx_on_reg;
  assign tx_busy  = (tx_left_reg != 4'h0);

  // bit timing
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      tx_rt_reg <= 4'h0;
    end else if (rt_tick) begin
      tx_rt_reg <= tx_rt_reg + 4'h1;
    end
  end

  // shifter: preamble first, then break, then buffered data
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      tx_sh_reg   <= '1;
      tx_left_reg <= 4'h0;
    end else if (ld_pre) begin
      tx_sh_reg   <= '1;
      tx_left_reg <= frame_bits(word9_reg);
    end else if (ld_brk) begin
      tx_sh_reg   <= '0;
      tx_left_reg <= frame_bits(word9_reg);
    end else if (ld_data) begin
      // stop (sent in nine bit frames only), ninth (or stop), data, start
      tx_sh_reg   <= {1'b1, (word9_reg ? tx9_reg : 1'b1), tx_buf_reg, 1'b0};
      tx_left_reg <= frame_bits(word9_reg);
    end else if (tx_load) begin
      tx_sh_reg   <= '1;
      tx_left_reg <= 4'h0;
    end else if (bit_tick && tx_busy) begin
      tx_sh_reg   <= {1'b1, tx_sh_reg[10:1]};
      tx_left_reg <= tx_left_reg - 4'h1;
    end
  end

  // queued preamble and break
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      tx_on_q_reg  <= 1'b0;
      pre_pend_reg <= 1'b0;
      brk_pend_reg <= 1'b0;
    end else begin
      tx_on_q_reg <= tx_on_reg;
      if (tx_on_reg && !tx_on_q_reg) begin
        pre_pend_reg <= 1'b1;
      end else if (ld_pre) begin
        pre_pend_reg <= 1'b0;
      end
      if (reg_wr && reg_addr == ADDR_CTRL2 && reg_wdata[C2_BREAK]) begin
        brk_pend_reg <= 1'b1;
      end else if (ld_brk) begin
        brk_pend_reg <= 1'b0;
      end
    end
  end

  // line driver, registered so the pin never glitches
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      txd <= 1'b1;
    end else begin
      txd <= (tx_busy || tx_on_reg) ? tx_sh_reg[0] : 1'b1;
    end
  end

  // -----------------------------------------------------------------
  // receiver
  // -----------------------------------------------------------------
  logic        rx_s1_reg, rx_s2_reg;  // two stage synchroniser
  logic        rx_prev_reg;           // previous synced level
  asu_rx_e     rx_state_reg;
  logic [3:0]  rx_rt_reg;             // sample count within a bit
  logic [3:0]  rx_idx_reg;            // bit index, 0 is start
  logic [1:0]  rx_samp_reg;           // first two samples
  logic [8:0]  rx_sh_reg;             // data shifter, fills from the top
  logic        rx_noisy_reg;          // any bit not unanimous
  logic [3:0]  ndata;                 // data bits per frame
  logic        decide, bit_val, bit_noisy, xfer, addr_wake;
  logic [2:0]  samples;

  assign ndata     = word9_reg ? 4'h9 : 4'h8;
  assign samples   = {rx_samp_reg, rx_s2_reg};
  assign decide    = (rx_state_reg == ASU_RX_BITS) && rt_tick && (rx_rt_reg == SAMP_C);
  assign bit_val   = vote(samples);
  assign bit_noisy = !(&samples) && (|samples);
  assign xfer      = decide && (rx_idx_reg == ndata + 4'h1);
  assign addr_wake = decide && (rx_idx_reg == ndata) && bit_val
                     && wake_addr_reg && sleep_reg;

  // synchroniser
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      rx_s1_reg   <= 1'b1;
      rx_s2_reg   <= 1'b1;
      rx_prev_reg <= 1'b1;
    end else begin
      rx_s1_reg   <= rxd;
      rx_s2_reg   <= rx_s1_reg;
      rx_prev_reg <= rx_s2_reg;
    end
  end

  // character sequencer
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      rx_state_reg <= ASU_RX_IDLE;
      rx_rt_reg    <= 4'h0;
      rx_idx_reg   <= 4'h0;
      rx_samp_reg  <= 2'b11;
      rx_sh_reg    <= 9'h000;
      rx_noisy_reg <= 1'b0;
    end else begin
      unique case (rx_state_reg)
        ASU_RX_IDLE: begin
          // a fall after a high level opens a character
          if (rx_on_reg && rx_prev_reg && !rx_s2_reg) begin
            rx_state_reg <= ASU_RX_BITS;
            rx_rt_reg    <= 4'h0;
            rx_idx_reg   <= 4'h0;
            rx_noisy_reg <= 1'b0;
          end
        end
        ASU_RX_BITS: begin
          if (rt_tick) begin
            rx_rt_reg <= rx_rt_reg + 4'h1;
            if (rx_rt_reg == SAMP_A) rx_samp_reg[1] <= rx_s2_reg;
            if (rx_rt_reg == SAMP_B) rx_samp_reg[0] <= rx_s2_reg;
          end
          if (decide) begin
            rx_noisy_reg <= rx_noisy_reg | bit_noisy;
            rx_idx_reg   <= rx_idx_reg + 4'h1;
            if (rx_idx_reg == 4'h0 && bit_val) begin
              rx_state_reg <= ASU_RX_IDLE;
            end else if (xfer) begin
              rx_state_reg <= ASU_RX_IDLE;
            end else if (rx_idx_reg != 4'h0) begin
              rx_sh_reg <= {bit_val, rx_sh_reg[8:1]};
            end
          end
        end
      endcase
    end
  end

  // idle detection: a full frame of ones
  logic [7:0] idle_cnt_reg;           // sample ticks of continuous high
  logic       idle_armed_reg;         // line was active since last idle
  logic       idle_hit;
  assign idle_hit = rt_tick && rx_s2_reg && idle_armed_reg &&
                    (idle_cnt_reg == {frame_bits(word9_reg), 4'h0} - 8'h01);

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      idle_cnt_reg   <= 8'h00;
      idle_armed_reg <= 1'b0;
    end else begin
      if (!rx_s2_reg) begin
        idle_cnt_reg   <= 8'h00;
        idle_armed_reg <= 1'b1;
      end else begin
        if (rt_tick && idle_cnt_reg != 8'hff) idle_cnt_reg <= idle_cnt_reg + 8'h01;
        if (idle_hit) idle_armed_reg <= 1'b0;
      end
    end
  end

  // -----------------------------------------------------------------
  // control registers
  // -----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      rate_reg      <= RATE_RESET;
      word9_reg     <= 1'b0;
      wake_addr_reg <= 1'b0;
      tx9_reg       <= 1'b0;
      c2_hi_reg     <= 4'h0;
      tx_on_reg     <= 1'b0;
      rx_on_reg     <= 1'b0;
      brk_reg       <= 1'b0;
      tx_buf_reg    <= 8'h00;
    end else if (reg_wr) begin
      if (reg_addr == ADDR_RATE) rate_reg <= reg_wdata;
      if (reg_addr == ADDR_CTRL1) begin
        tx9_reg       <= reg_wdata[C1_TX9];
        word9_reg     <= reg_wdata[C1_WORD9];
        wake_addr_reg <= reg_wdata[C1_WAKE];
      end
      if (reg_addr == ADDR_CTRL2) begin
        c2_hi_reg <= reg_wdata[7:4];
        tx_on_reg <= reg_wdata[C2_TXON];
        rx_on_reg <= reg_wdata[C2_RXON];
        brk_reg   <= reg_wdata[C2_BREAK];
      end
      if (wr_data) tx_buf_reg <= reg_wdata;
    end
  end

  // sleep: software sets, a wake event clears; a write in the same cycle wins
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      sleep_reg <= 1'b0;
    end else if (reg_wr && reg_addr == ADDR_CTRL2) begin
      sleep_reg <= reg_wdata[C2_SLEEP];
    end else if (addr_wake) begin
      sleep_reg <= 1'b0;
    end else if (idle_hit && !wake_addr_reg) begin
      sleep_reg <= 1'b0;
    end
  end

  // -----------------------------------------------------------------
  // status flags
  // -----------------------------------------------------------------
  logic rx_clr, tx_clr, store;
  assign rx_clr = rd_data;            // second half of the clear sequence
  assign tx_clr = wr_data;
  assign store  = xfer && !sleep_reg && !rxf_reg && !fe_reg;

  // status read arms the flags that were set at that moment
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      arm_reg <= 8'h00;
    end else if (rd_stat) begin
      arm_reg <= status;
    end else if (rd_data || wr_data) begin
      arm_reg <= 8'h00;
    end
  end

  // receive buffer and receive flags; a set beats a clear
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      rx_buf_reg <= 8'h00;
      rx9_reg    <= 1'b0;
      rxf_reg    <= 1'b0;
      idle_reg   <= 1'b0;
      ovr_reg    <= 1'b0;
      noise_reg  <= 1'b0;
      fe_reg     <= 1'b0;
    end else begin
      if (store) begin
        rx_buf_reg <= word9_reg ? rx_sh_reg[7:0] : rx_sh_reg[8:1];
        rx9_reg    <= rx_sh_reg[8];
      end
      if (store) rxf_reg <= 1'b1;
      else if (rx_clr && arm_reg[ST_RXF]) rxf_reg <= 1'b0;
      if (store && !bit_val) fe_reg <= 1'b1;
      else if (rx_clr && arm_reg[ST_FRAME]) fe_reg <= 1'b0;
      if (store && (rx_noisy_reg || bit_noisy)) noise_reg <= 1'b1;
      else if (rx_clr && arm_reg[ST_NOISE]) noise_reg <= 1'b0;
      if (xfer && !sleep_reg && rxf_reg) ovr_reg <= 1'b1;
      else if (rx_clr && arm_reg[ST_OVR]) ovr_reg <= 1'b0;
      if (idle_hit && !sleep_reg) idle_reg <= 1'b1;
      else if (rx_clr && arm_reg[ST_IDLE]) idle_reg <= 1'b0;
    end
  end

  // transmit flags: a data write refills the buffer, so it beats the load
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      txe_reg <= 1'b1;
      txc_reg <= 1'b1;
    end else begin
      if (tx_clr && arm_reg[ST_TXE]) txe_reg <= 1'b0;
      else if (ld_data) txe_reg <= 1'b1;
      if (!tx_busy && !pre_pend_reg && !brk_pend_reg && !brk_reg) txc_reg <= 1'b1;
      else if (tx_clr && arm_reg[ST_TXC]) txc_reg <= 1'b0;
    end
  end

  // -----------------------------------------------------------------
  // read port, data one cycle after the strobe
  // -----------------------------------------------------------------
  assign status = {txe_reg, txc_reg, rxf_reg, idle_reg, ovr_reg, noise_reg, fe_reg, 1'b0};

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      unique case (reg_addr)
        ADDR_RATE:  reg_rdata <= rate_reg;
        ADDR_CTRL1: reg_rdata <= {rx9_reg, tx9_reg, 1'b0, word9_reg, wake_addr_reg, 3'b000};
        ADDR_CTRL2: reg_rdata <= {c2_hi_reg, tx_on_reg, rx_on_reg, sleep_reg, brk_reg};
        ADDR_STAT:  reg_rdata <= status;
        ADDR_DATA:  reg_rdata <= rx_buf_reg;
        default:    reg_rdata <= 8'h00;  // unmapped reads as zero
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // -----------------------------------------------------------------
  // assertions
  // -----------------------------------------------------------------
  a_line_idle_high: assert property (@(posedge sys_clk) disable iff (!nrst)
    (!$past(tx_busy) && !$past(tx_on_reg)) |-> txd)
    else $error("line not high while transmitter idle");
  a_start_bit_low: assert property (@(posedge sys_clk) disable iff (!nrst)
    ld_data |=> ##1 !txd)
    else $error("start bit not driven low");
  a_break_low: assert property (@(posedge sys_clk) disable iff (!nrst)
    ld_brk |=> ##1 (!txd && tx_busy))
    else $error("break not driven low");
  a_preamble_queued: assert property (@(posedge sys_clk) disable iff (!nrst)
    (tx_on_reg && !tx_on_q_reg) |=> pre_pend_reg)
    else $error("preamble not queued on enable");
  a_sleep_blocks: assert property (@(posedge sys_clk) disable iff (!nrst)
    sleep_reg |=> !$rose(rxf_reg) && !$rose(idle_reg) && !$rose(ovr_reg))
    else $error("flag set while asleep");
  a_overrun_keeps: assert property (@(posedge sys_clk) disable iff (!nrst)
    (xfer && !sleep_reg && rxf_reg) |=> (ovr_reg && $stable(rx_buf_reg)))
    else $error("overrun handling wrong");
  a_frame_with_full: assert property (@(posedge sys_clk) disable iff (!nrst)
    $rose(fe_reg) |-> $rose(rxf_reg))
    else $error("frame error without full");
  a_noise_needs_full: assert property (@(posedge sys_clk) disable iff (!nrst)
    $rose(noise_reg) |-> rxf_reg)
    else $error("noise set before full");
  a_addr_wakes: assert property (@(posedge sys_clk) disable iff (!nrst)
    (addr_wake && !reg_wr) |=> (!sleep_reg && rx_state_reg == ASU_RX_BITS))
    else $error("address mark did not wake before stop");
endmodule : asu_serial

// [verification/asu_remote.sv]
`timescale 1ns/1ps
// remote station on the far end of the serial pair
module asu_remote (
  // clock
  input  wire logic sys_clk,
  // serial pair
  input  wire logic txd,
  output logic      rxd
);
  initial rxd = 1'b1;  // line idles high
  // ---------------------------------------------------------------
  // sender: start, data lsb first, stop, sixteen clocks a bit
  // ---------------------------------------------------------------
  task automatic send(input logic [8:0] d, input int n, input logic stp);
    logic b;
    for (int i = 0; i <= n + 1; i++) begin
      b = (i == 0) ? 1'b0 : (i <= n) ? d[i-1] : stp;
      @(posedge sys_clk) rxd <= b;
      repeat (15) @(posedge sys_clk);
    end
    @(posedge sys_clk) rxd <= 1'b1;  // no gap inside a message
  endtask : send
  // catcher: samples mid-bit so small skew does not matter
  task automatic grab(output logic [8:0] d, output logic stp, input int n);
    d = '0;
    @(negedge txd);
    repeat (8) @(posedge sys_clk);
    for (int i = 0; i <= n; i++) begin
      repeat (16) @(posedge sys_clk);
      if (i < n) d[i] = txd;
      else stp = txd;
    end
  endtask : grab
endmodule : asu_remote

// [verification/tb.sv]
`timescale 1ns/1ps
module tb;
  import asu_pkg::*;
  logic        sys_clk = 1'b0, nrst = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, rxd, txd, s;
  logic [15:0] reg_addr = '0;
  logic [7:0]  reg_wdata = '0, reg_rdata, v, a, b;
  logic [8:0]  g1, g2;
  int          fail_count = 0, check_count = 0, cyc = 0, t;
  always #10 sys_clk = ~sys_clk;
  asu_serial dut_u (.sys_clk(sys_clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rxd(rxd), .txd(txd));
  asu_remote peer_u (.sys_clk(sys_clk), .txd(txd), .rxd(rxd));
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic chk(input string nm, input logic [8:0] got, input logic [8:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [15:0] ad, input logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= ad;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk) reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [15:0] ad, output logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= ad;
    reg_rd <= 1'b1;
    @(posedge sys_clk) reg_rd <= 1'b0;
    @(negedge sys_clk) d = reg_rdata;  // data stand one cycle only
  endtask : rd
  // poll until the transmit buffer is free, bounded
  task automatic wait_txe();
    // a preamble or a nine bit frame, plus a divider wrap, fits inside this bound
    for (int i = 0; i < 300; i++) begin
      rd(ADDR_STAT, v);
      if (v[ST_TXE] === 1'b1) break;
    end
    chk("tx empty", 9'(v[ST_TXE]), 9'h1);
  endtask : wait_txe
  // expected receive flags: full, overrun, frame; noise expected clear
  function automatic logic [7:0] flg(input bit f, input bit o, input bit fe);
    return {2'b00, f, 1'b0, o, 1'b0, fe, 1'b0};
  endfunction : flg
  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : summarize
  // hang guard, far above the few thousand cycles the run needs
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      fail_count++;
      summarize();
    end
  end
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    void'($urandom(32'h0b73981c));
    repeat (5) @(posedge sys_clk);
    nrst <= 1'b1;
    rd(ADDR_STAT, v); chk("status", v, 8'hc0);
    rd(16'h1030, v); chk("unmapped", v, 8'h00);
    a = 8'($urandom);
    b = 8'($urandom);
    // divider readback with a random value, then back to one tick a clock
    wr(ADDR_RATE, a);
    rd(ADDR_RATE, v);
    chk("rate", v, a);
    wr(ADDR_RATE, RATE_RESET);
    // preamble, then two words queued back to back
    fork
      begin peer_u.grab(g1, s, 8); peer_u.grab(g2, s, 8); end
      begin t = cyc; @(negedge txd); t = cyc - t; end
      begin wr(ADDR_CTRL2, 8'h0c); wr(ADDR_DATA, a); wait_txe(); wr(ADDR_DATA, b); end
    join
    chk("preamble", 9'(t >= 160), 9'h1);
    chk("tx first", g1, {1'b0, a});
    chk("tx second", g2, {1'b0, b});
    chk("tx stop", 9'(s), 9'h1);
    // nine bit word with the ninth bit from control one
    wr(ADDR_CTRL1, 8'h50);
    wait_txe();
    fork peer_u.grab(g1, s, 9); wr(ADDR_DATA, b); join
    chk("tx nine", g1, {1'b1, b});
    wr(ADDR_CTRL1, 8'h00);
    // one break queued by a write, the break level released at once
    fork
      peer_u.grab(g1, s, 8);
      begin wr(ADDR_CTRL2, 8'h0d); wr(ADDR_CTRL2, 8'h0c); end
    join
    chk("break", {s, g1[7:0]}, 9'h000);
    // plain receive
    peer_u.send({1'b0, a}, 8, 1'b1);
    rd(ADDR_STAT, v); chk("rx flags", v & 8'h2e, flg(1, 0, 0));
    rd(ADDR_DATA, v); chk("rx data", v, a);
    // overrun on a frame with a bad stop bit
    peer_u.send({1'b0, b}, 8, 1'b1);
    peer_u.send({1'b0, a}, 8, 1'b0);
    rd(ADDR_STAT, v); chk("overrun", v & 8'h2e, flg(1, 1, 0));
    rd(ADDR_DATA, v); chk("kept data", v, b);
    rd(ADDR_STAT, v); chk("cleared", v & 8'h2e, flg(0, 0, 0));
    // framing error
    peer_u.send({1'b0, a}, 8, 1'b0);
    rd(ADDR_STAT, v); chk("frame", v & 8'h2e, flg(1, 0, 1));
    rd(ADDR_DATA, v);
    rd(ADDR_STAT, v); chk("frame clr", v & 8'h2e, flg(0, 0, 0));
    // sleep in mid message, idle line wakes it
    fork
      begin peer_u.send({1'b0, a}, 8, 1'b1); peer_u.send({1'b0, b}, 8, 1'b1); end
      begin repeat (40) @(posedge sys_clk); wr(ADDR_CTRL2, 8'h0e); end
    join
    rd(ADDR_STAT, v); chk("asleep", v & 8'h2e, flg(0, 0, 0));
    repeat (200) @(posedge sys_clk);
    rd(ADDR_CTRL2, v); chk("idle wake", v, 8'h0c);
    rd(ADDR_STAT, v);
    chk("idle held", 9'(v[ST_IDLE]), 9'h0);
    // address mark wake
    wr(ADDR_CTRL1, 8'h08);
    wr(ADDR_CTRL2, 8'h0e);
    peer_u.send(9'h005, 8, 1'b1);
    rd(ADDR_CTRL2, v); chk("no mark", v, 8'h0e);
    peer_u.send({1'b0, a | 8'h80}, 8, 1'b1);
    rd(ADDR_STAT, v); chk("mark full", v & 8'h2e, flg(1, 0, 0));
    rd(ADDR_DATA, v); chk("mark data", v, a | 8'h80);
    // nine bit receive, the ninth bit lands in control one
    wr(ADDR_CTRL1, 8'h10);
    peer_u.send({1'b1, b}, 9, 1'b1);
    rd(ADDR_STAT, v);
    chk("rx9 flags", v & 8'h2e, flg(1, 0, 0));
    rd(ADDR_CTRL1, v);
    chk("rx ninth", 9'(v[C1_RX9]), 9'h1);
    rd(ADDR_DATA, v);
    chk("rx9 data", v, b);
    // the frames above were line activity, so a quiet line raises idle again
    repeat (200) @(posedge sys_clk);
    rd(ADDR_STAT, v);
    chk("idle", 9'(v[ST_IDLE]), 9'h1);
    summarize();
  end
endmodule : tb
